/* rtl/sysopt_map.vh */
`ifndef SYSOPT_MAP_VH
`define SYSOPT_MAP_VH

// register offsets on the plain register port
`define OFS_SYSTEM_OPTIONS_ONE 3'h0
`define OFS_SYSTEM_OPTIONS_TWO 3'h1
`define OFS_DEVICE_IDENT_HIGH 3'h2
`define OFS_DEVICE_IDENT_LOW 3'h3
`define OFS_PERIODIC_WAKEUP_CONTROL 3'h4

// system_options_one field positions
`define BIT_WATCHDOG_ENABLE 7
`define BIT_WATCHDOG_LONG_TIMEOUT 6
`define BIT_STOP_ALLOW 5
`define BIT_OPT_RESERVED 4
`define BIT_DEBUG_PIN_SELECT 1
`define BIT_RESET_PIN_SELECT 0

// system_options_one reset values
`define RST_WATCHDOG_ENABLE 1'h1
`define RST_WATCHDOG_LONG_TIMEOUT 1'h1
`define RST_STOP_ALLOW 1'h0
`define RST_OPT_RESERVED 1'h1
`define RST_DEBUG_PIN_SELECT 1'h1
`define POR_RESET_PIN_SELECT 1'h0

// system_options_two field position and reset value
`define BIT_WATCHDOG_CLOCK_SELECT 7
`define RST_WATCHDOG_CLOCK_SELECT 1'h0

// periodic_wakeup_control field positions
`define BIT_WAKEUP_FLAG 7
`define BIT_WAKEUP_FLAG_CLEAR 6
`define BIT_WAKEUP_CLOCK_SELECT 5
`define BIT_WAKEUP_IRQ_ENABLE 4
`define MSB_WAKEUP_PERIOD_SELECT 2
`define LSB_WAKEUP_PERIOD_SELECT 0

// periodic_wakeup_control reset values
`define RST_WAKEUP_CLOCK_SELECT 1'h0
`define RST_WAKEUP_IRQ_ENABLE 1'h0
`define RST_WAKEUP_PERIOD_SELECT 3'h0

// wakeup periods in source ticks, 1 kHz source (1 ms tick)
`define SLOW_TICKS_1 16'h0008
`define SLOW_TICKS_2 16'h0020
`define SLOW_TICKS_3 16'h0040
`define SLOW_TICKS_4 16'h0080
`define SLOW_TICKS_5 16'h0100
`define SLOW_TICKS_6 16'h0200
`define SLOW_TICKS_7 16'h0400

// wakeup periods in source ticks, 32 kHz source
`define FAST_TICKS_1 16'h0100
`define FAST_TICKS_2 16'h0400
`define FAST_TICKS_3 16'h0800
`define FAST_TICKS_4 16'h1000
`define FAST_TICKS_5 16'h2000
`define FAST_TICKS_6 16'h4000
`define FAST_TICKS_7 16'h8000

`endif

/* rtl/system_options_and_periodic_wakeup.v */
`timescale 1ns/1ns
`default_nettype none
`include "sysopt_map.vh"

module system_options_and_periodic_wakeup #(
    parameter [11:0] PART_NUMBER = 12'h5a3, // arbitrary neutral value
    parameter [3:0] MASK_REVISION = 4'h2 // arbitrary neutral value
) (
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    input wire power_on_reset,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire stop_execute,
    output reg stop_enter,
    output reg illegal_opcode_reset,
    input wire osc_1khz,
    input wire clk_32khz,
    output wire watchdog_enable,
    output wire watchdog_long_timeout,
    output wire watchdog_clock_select,
    output wire stop_allow,
    output wire debug_pin_select,
    output wire reset_pin_select,
    output wire reset_pullup_enable,
    output wire wakeup_flag,
    output wire wakeup_irq
);

    // option register state
    reg watchdog_enable_q;
    reg watchdog_long_timeout_q;
    reg stop_allow_q;
    reg opt_reserved_q;
    reg debug_pin_select_q;
    reg reset_pin_select_q;
    reg options_one_locked_q;
    reg watchdog_clock_select_q;
    reg options_two_locked_q;

    // wakeup control state
    reg wakeup_flag_q;
    reg wakeup_clock_select_q;
    reg wakeup_irq_enable_q;
    reg [2:0] wakeup_period_select_q;
    reg [15:0] wakeup_count_q;
    reg [15:0] wakeup_count_d;
    reg wakeup_flag_d;

    // source synchronisers
    reg slow_s1_q;
    reg slow_s2_q;
    reg slow_s3_q;
    reg fast_s1_q;
    reg fast_s2_q;
    reg fast_s3_q;

    wire wr_opt_one;
    wire wr_opt_two;
    wire wr_wakeup;
    wire slow_edge;
    wire fast_edge;
    wire source_edge;
    wire [15:0] wakeup_terminal;
    wire wakeup_config_change;
    wire wakeup_timeout;
    wire [7:0] opt_one_value;
    wire [7:0] opt_two_value;
    wire [7:0] wakeup_value;
    reg [7:0] read_mux;

    // terminal count for a period code, zero when disabled
    function [15:0] period_ticks;
        input fast_source;
        input [2:0] code;
        begin
            period_ticks = 16'h0000;
            case (code)
                3'h1: period_ticks = fast_source ? `FAST_TICKS_1 : `SLOW_TICKS_1;
                3'h2: period_ticks = fast_source ? `FAST_TICKS_2 : `SLOW_TICKS_2;
                3'h3: period_ticks = fast_source ? `FAST_TICKS_3 : `SLOW_TICKS_3;
                3'h4: period_ticks = fast_source ? `FAST_TICKS_4 : `SLOW_TICKS_4;
                3'h5: period_ticks = fast_source ? `FAST_TICKS_5 : `SLOW_TICKS_5;
                3'h6: period_ticks = fast_source ? `FAST_TICKS_6 : `SLOW_TICKS_6;
                3'h7: period_ticks = fast_source ? `FAST_TICKS_7 : `SLOW_TICKS_7;
                default: period_ticks = 16'h0000;
            endcase
        end
    endfunction

    // register write decode
    assign wr_opt_one = reg_wr && (reg_addr == `OFS_SYSTEM_OPTIONS_ONE);
    assign wr_opt_two = reg_wr && (reg_addr == `OFS_SYSTEM_OPTIONS_TWO);
    assign wr_wakeup = reg_wr && (reg_addr == `OFS_PERIODIC_WAKEUP_CONTROL);

    // main options: first write after reset wins, later ones dropped
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_enable_q <= `RST_WATCHDOG_ENABLE;
            watchdog_long_timeout_q <= `RST_WATCHDOG_LONG_TIMEOUT;
            stop_allow_q <= `RST_STOP_ALLOW;
            opt_reserved_q <= `RST_OPT_RESERVED;
            debug_pin_select_q <= `RST_DEBUG_PIN_SELECT;
            options_one_locked_q <= 1'h0;
        end else if (clk_en) begin
            if (wr_opt_one && !options_one_locked_q) begin
                watchdog_enable_q <= reg_wdata[`BIT_WATCHDOG_ENABLE];
                watchdog_long_timeout_q <= reg_wdata[`BIT_WATCHDOG_LONG_TIMEOUT];
                stop_allow_q <= reg_wdata[`BIT_STOP_ALLOW];
                opt_reserved_q <= reg_wdata[`BIT_OPT_RESERVED];
                debug_pin_select_q <= reg_wdata[`BIT_DEBUG_PIN_SELECT];
                options_one_locked_q <= 1'h1;
            end
        end
    end

    // reset pin select survives warm resets; only power-on clears it
    always @(posedge clock) begin
        if (clk_en) begin
            if (power_on_reset) begin
                reset_pin_select_q <= `POR_RESET_PIN_SELECT;
            end else if (rst_n && wr_opt_one && !options_one_locked_q) begin
                reset_pin_select_q <= reg_wdata[`BIT_RESET_PIN_SELECT];
            end
        end
    end

    // watchdog clock select, its own write-once latch
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_clock_select_q <= `RST_WATCHDOG_CLOCK_SELECT;
            options_two_locked_q <= 1'h0;
        end else if (clk_en) begin
            if (wr_opt_two && !options_two_locked_q) begin
                watchdog_clock_select_q <= reg_wdata[`BIT_WATCHDOG_CLOCK_SELECT];
                options_two_locked_q <= 1'h1;
            end
        end
    end

    // stop request: enter stop if allowed, otherwise illegal opcode reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stop_enter <= 1'h0;
            illegal_opcode_reset <= 1'h0;
        end else if (clk_en) begin
            stop_enter <= stop_execute && stop_allow_q;
            illegal_opcode_reset <= stop_execute && !stop_allow_q;
        end
    end

    // two-stage synchronisers plus an edge-history stage
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slow_s1_q <= 1'h0;
            slow_s2_q <= 1'h0;
            slow_s3_q <= 1'h0;
            fast_s1_q <= 1'h0;
            fast_s2_q <= 1'h0;
            fast_s3_q <= 1'h0;
        end else if (clk_en) begin
            slow_s1_q <= osc_1khz;
            slow_s2_q <= slow_s1_q;
            slow_s3_q <= slow_s2_q;
            fast_s1_q <= clk_32khz;
            fast_s2_q <= fast_s1_q;
            fast_s3_q <= fast_s2_q;
        end
    end

    // rising edges of the selected wakeup source
    assign slow_edge = slow_s2_q && !slow_s3_q;
    assign fast_edge = fast_s2_q && !fast_s3_q;
    assign source_edge = wakeup_clock_select_q ? fast_edge : slow_edge;

    // selected period; code zero gives zero and stops the timer
    assign wakeup_terminal = period_ticks(wakeup_clock_select_q, wakeup_period_select_q);

    // a new source or period restarts the count from zero
    assign wakeup_config_change = wr_wakeup &&
        ((reg_wdata[`BIT_WAKEUP_CLOCK_SELECT] != wakeup_clock_select_q) ||
        (reg_wdata[`MSB_WAKEUP_PERIOD_SELECT:`LSB_WAKEUP_PERIOD_SELECT] !=
        wakeup_period_select_q));

    assign wakeup_timeout = source_edge && (wakeup_terminal != 16'h0000) &&
        (wakeup_count_q == wakeup_terminal - 16'h0001);

    // tick counter and flag; a timeout beats a same-cycle clear unless that write also changes the source or period
    always @* begin
        wakeup_count_d = wakeup_count_q;
        wakeup_flag_d = wakeup_flag_q;
        if (wakeup_terminal == 16'h0000 || wakeup_config_change) begin
            wakeup_count_d = 16'h0000;
        end else if (wakeup_timeout) begin
            wakeup_count_d = 16'h0000;
        end else if (source_edge) begin
            wakeup_count_d = wakeup_count_q + 16'h0001;
        end
        if (wr_wakeup && reg_wdata[`BIT_WAKEUP_FLAG_CLEAR]) begin
            wakeup_flag_d = 1'h0;
        end
        if (wakeup_timeout && !wakeup_config_change) begin
            wakeup_flag_d = 1'h1;
        end
    end

    // wakeup control register and timer state
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wakeup_flag_q <= 1'h0;
            wakeup_clock_select_q <= `RST_WAKEUP_CLOCK_SELECT;
            wakeup_irq_enable_q <= `RST_WAKEUP_IRQ_ENABLE;
            wakeup_period_select_q <= `RST_WAKEUP_PERIOD_SELECT;
            wakeup_count_q <= 16'h0000;
        end else if (clk_en) begin
            wakeup_flag_q <= wakeup_flag_d;
            wakeup_count_q <= wakeup_count_d;
            if (wr_wakeup) begin
                wakeup_clock_select_q <= reg_wdata[`BIT_WAKEUP_CLOCK_SELECT];
                wakeup_irq_enable_q <= reg_wdata[`BIT_WAKEUP_IRQ_ENABLE];
                wakeup_period_select_q <=
                    reg_wdata[`MSB_WAKEUP_PERIOD_SELECT:`LSB_WAKEUP_PERIOD_SELECT];
            end
        end
    end

    // readback images; unused and write-only bits read zero
    assign opt_one_value = {watchdog_enable_q, watchdog_long_timeout_q, stop_allow_q,
        opt_reserved_q, 2'h0, debug_pin_select_q, reset_pin_select_q};
    assign opt_two_value = {watchdog_clock_select_q, 7'h00};
    assign wakeup_value = {wakeup_flag_q, 1'h0, wakeup_clock_select_q,
        wakeup_irq_enable_q, 1'h0, wakeup_period_select_q};

    // read select, unmapped offsets give zero
    always @* begin
        case (reg_addr)
            `OFS_SYSTEM_OPTIONS_ONE: read_mux = opt_one_value;
            `OFS_SYSTEM_OPTIONS_TWO: read_mux = opt_two_value;
            `OFS_DEVICE_IDENT_HIGH: read_mux = {MASK_REVISION, PART_NUMBER[11:8]};
            `OFS_DEVICE_IDENT_LOW: read_mux = PART_NUMBER[7:0];
            `OFS_PERIODIC_WAKEUP_CONTROL: read_mux = wakeup_value;
            default: read_mux = 8'h00;
        endcase
    end

    // read data stands in the cycle after the strobe only
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? read_mux : 8'h00;
        end
    end

    // option and request outputs
    assign watchdog_enable = watchdog_enable_q;
    assign watchdog_long_timeout = watchdog_long_timeout_q;
    assign watchdog_clock_select = watchdog_clock_select_q;
    assign stop_allow = stop_allow_q;
    assign debug_pin_select = debug_pin_select_q;
    assign reset_pin_select = reset_pin_select_q;
    assign reset_pullup_enable = reset_pin_select_q;
    assign wakeup_flag = wakeup_flag_q;
    assign wakeup_irq = wakeup_flag_q && wakeup_irq_enable_q;

endmodule // system_options_and_periodic_wakeup

`default_nettype wire

/* verification/sysopt_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module sysopt_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic power_on_reset,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic stop_execute,
    input wire logic stop_enter,
    input wire logic illegal_opcode_reset,
    input wire logic watchdog_enable,
    input wire logic watchdog_clock_select,
    input wire logic stop_allow,
    input wire logic debug_pin_select,
    input wire logic reset_pin_select,
    input wire logic reset_pullup_enable,
    input wire logic wakeup_flag,
    input wire logic wakeup_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic lock_q;
    // first options write since reset closes the lock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) lock_q <= 1'b0;
        else if (clk_en && reg_wr && reg_addr == 3'h0) lock_q <= 1'b1;
    end
    sequence s_opt_wr; clk_en && reg_wr && reg_addr == 3'h0; endsequence
    sequence s_stop; clk_en && stop_execute; endsequence
    sequence s_clr; clk_en && reg_wr && reg_addr == 3'h4 && reg_wdata[6]; endsequence
    AST_OPT_FIRST: assert property ((!lock_q ##0 s_opt_wr) |=>
        watchdog_enable == $past(reg_wdata[7]) && stop_allow == $past(reg_wdata[5])
        && debug_pin_select == $past(reg_wdata[1]) && reset_pin_select == $past(reg_wdata[0]))
        else $error("options first write not taken");
    AST_OPT_LOCKED: assert property ((lock_q ##0 s_opt_wr) |=>
        $stable(watchdog_enable) && $stable(stop_allow) && $stable(debug_pin_select))
        else $error("locked options changed");
    AST_STOP_OK: assert property ((s_stop ##0 stop_allow) |=>
        stop_enter && !illegal_opcode_reset) else $error("permitted stop not entered");
    AST_STOP_BAD: assert property ((s_stop ##0 !stop_allow) |=>
        illegal_opcode_reset && !stop_enter) else $error("forbidden stop not trapped");
    AST_STOP_IDLE: assert property (clk_en && !stop_execute |=>
        !stop_enter && !illegal_opcode_reset) else $error("stop pulse without cause");
    AST_RESET_VALUES: assert property ($rose(rst_n) |-> watchdog_enable
        && debug_pin_select && !stop_allow && !watchdog_clock_select && !wakeup_flag)
        else $error("wrong value after reset");
    AST_POR: assert property (clk_en && power_on_reset |=> !reset_pin_select)
        else $error("power-on did not clear reset pin select");
    AST_PULLUP: assert property (reset_pullup_enable == reset_pin_select)
        else $error("pullup does not follow reset pin select");
    AST_IRQ_GATE: assert property (!wakeup_flag |-> !wakeup_irq)
        else $error("irq without flag");
    AST_FLAG_CLEAR: assert property (s_clr |=> !wakeup_flag)
        else $error("flag not cleared");
    AST_FLAG_HOLD: assert property (wakeup_flag ##0 !reg_wr |=> wakeup_flag)
        else $error("flag dropped by itself");
endmodule // sysopt_chk
bind system_options_and_periodic_wakeup sysopt_chk chk_u (.clock, .rst_n, .clk_en,
    .power_on_reset, .reg_addr, .reg_wdata, .reg_wr, .stop_execute, .stop_enter,
    .illegal_opcode_reset, .watchdog_enable, .watchdog_clock_select, .stop_allow,
    .debug_pin_select, .reset_pin_select, .reset_pullup_enable, .wakeup_flag, .wakeup_irq);
`default_nettype wire

/* verification/tb_system_options_and_periodic_wakeup.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_system_options_and_periodic_wakeup;
    localparam [11:0] PN = 12'h3c7; // arbitrary
    localparam [3:0] REV = 4'h9; // arbitrary
    logic clock = 0, rst_n = 0, por = 1, wr = 0, rd = 0, stp = 0, osc = 0, f32 = 0, fast;
    logic [2:0] addr = 0, code;
    logic [7:0] wd = 0, rdat, o1, d, ctl;
    wire se, il, we, lt, wc, sa, dp, rp, pu, fl, irq;
    integer seed = 32'hd2964e85;
    int errors = 0, checks = 0, n, t, ticks, per, div = 0;
    system_options_and_periodic_wakeup #(.PART_NUMBER(PN), .MASK_REVISION(REV)) dut_u (
        .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .power_on_reset(por),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
        .stop_execute(stp), .stop_enter(se), .illegal_opcode_reset(il), .osc_1khz(osc),
        .clk_32khz(f32), .watchdog_enable(we), .watchdog_long_timeout(lt),
        .watchdog_clock_select(wc), .stop_allow(sa), .debug_pin_select(dp),
        .reset_pin_select(rp), .reset_pullup_enable(pu), .wakeup_flag(fl), .wakeup_irq(irq));
    always #4 clock = ~clock;
    // slow source period 6 clocks, fast source period 8 clocks
    always @(posedge clock) begin
        div <= div + 1;
        if (div % 3 == 2) osc <= ~osc;
        if (div % 4 == 3) f32 <= ~f32;
    end
    task end_sim;
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wrt(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wd <= v;
        wr <= 1;
        @(posedge clock);
        wr <= 0;
    endtask
    task rdc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1;
        @(posedge clock);
        rd <= 0;
        #1 chk(rdat, e);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1;
        repeat (2) @(posedge clock);
        por <= 0;
        rdc(0, 8'hd2);
        wrt(2, 8'hff);
        wrt(3, 8'hff);
        rdc(2, {REV, PN[11:8]});
        rdc(3, PN[7:0]);
        rdc(7, 8'h00);
        for (n = 0; n < 2; n++) begin
            d = $random(seed);
            d[5] = n[0];
            wrt(0, d);
            o1 = d & 8'hf3;
            wrt(0, ~d);
            rdc(0, o1);
            chk({we, lt, sa, 3'b000, dp, rp}, o1 & 8'he3);
            chk(pu, rp);
            @(posedge clock);
            stp <= 1;
            @(posedge clock);
            stp <= 0;
            #1 chk({se, il}, {o1[5], ~o1[5]});
            d = $random(seed);
            wrt(1, d);
            wrt(1, ~d);
            rdc(1, d & 8'h80);
            chk(wc, d[7]);
            @(posedge clock);
            rst_n <= 0;
            repeat (3) @(posedge clock);
            rst_n <= 1;
            rdc(0, 8'hd2 | (o1 & 8'h01));
            rdc(1, 8'h00);
        end
        for (n = 1; n < 11; n++) begin
            fast = n > 7;
            code = fast ? n - 7 : n;
            ctl = {2'b01, fast, code[0], 1'b0, code};
            ticks = (fast ? 256 : 8) << (code > 1 ? code : 0);
            per = fast ? 8 : 6;
            wrt(4, ctl);
            t = 0;
            while (fl !== 1'b1 && t < ticks * per * 2 + 100) begin
                @(posedge clock);
                #1 t++;
            end
            chk(fl, 1);
            if (fl !== 1'b1) end_sim;
            chk(t >= (ticks - 1) * per && t <= ticks * per + per + 8, 1);
            chk(irq, code[0]);
            rdc(4, ctl ^ 8'hc0);
            wrt(4, ctl);
            rdc(4, ctl & 8'hbf);
        end
        wrt(4, 8'h60);
        repeat (3000) @(posedge clock);
        chk(fl, 0);
        rdc(4, 8'h20);
        end_sim;
    end
endmodule // tb_system_options_and_periodic_wakeup
`default_nettype wire
